// >>> inc/cfgrg_defines.vh
// Constants of the control and file-system status register block.
// Included by the register block; definitions only.
`ifndef CFGRG_DEFINES_VH
`define CFGRG_DEFINES_VH

// Byte addresses on the host bus (word address = byte address / 2)
`define CFGRG_ADDR_CTRL_LO   7'h18
`define CFGRG_ADDR_CTRL_HI   7'h1A
`define CFGRG_ADDR_FATSTAT   7'h1C

// Control register fields (bit positions in the 32-bit register)
`define CFGRG_CTRL_OVR_BIT   2
`define CFGRG_CTRL_DIE_BIT   10
`define CFGRG_CTRL_CLR_BIT   11
`define CFGRG_CTRL_PROG_BIT  12
`define CFGRG_CTRL_OFS_LSB   13
`define CFGRG_CTRL_OFS_MSB   15

// Reset values
`define CFGRG_CTRL_RST       32'h0000_0000
`define CFGRG_FAT_RST        8'h00

// Cluster-count limits for the computed FAT type
`define CFGRG_FAT12_LIMIT    32'h0000_0FF5
`define CFGRG_FAT16_LIMIT    32'h0000_FFF5

`endif

// >>> rtl/cfgrg_regs.v
// Control register (upper part plus offset override) and file-system status register.
// Assumes a same-clock host bus front end giving one-cycle read/write strobes,
// a boot-record parser on SYS_CLK, and offset pins arriving asynchronously.
//
// Notes on behaviour
// RULE_01: Control bit 10 enables the configuration-done interrupt and resets to zero.
// RULE_02: Writing one to control bit 11 drops the interrupt request at once.
// RULE_03: While control bit 11 holds one no new interrupt is raised; zero re-arms it.
// RULE_04: Control bit 12 drives the active-low program pin inverted and resets to zero.
// RULE_05: Control bits 15..13 form the configuration offset, bit 13 least significant.
// RULE_06: The register offset replaces the offset pins only while control bit 2 is one.
// RULE_07: The host writes zero to control bits 18..16; bits 31..19 have no function.
// RULE_08: The status register describes the first valid partition of the card.
// RULE_09: Status bit 0 shows that a valid master boot record was found.
// RULE_10: Status bit 1 shows that a valid partition boot record was found.
// RULE_11: Status bits 2 and 4 show the FAT12 and FAT16 marks of the master record.
// RULE_12: Status bits 3 and 5 show the FAT12 and FAT16 marks of the partition record.
// RULE_13: Status bit 6 is one when the cluster count is below 4085.
// RULE_14: Status bit 7 is one when the cluster count lies above 4085 and below the FAT16 limit.
// RULE_15: The status register is read-only, reads have no side effect, bits 15..8 read zero.
// RULE_16: Status flags reset to zero and change only when the parser reports completion.
`timescale 1ns/1ps
`include "cfgrg_defines.vh"

module cfgrg_regs #(
  parameter CNT_W = 32
)(
  input  wire             SYS_CLK,
  input  wire             RST,
  input  wire [6:0]       BUS_ADDR,
  input  wire             BUS_WR,
  input  wire             BUS_RD,
  input  wire [1:0]       BUS_BE,
  input  wire [15:0]      BUS_WDATA,
  output wire [15:0]      BUS_RDATA,
  output wire             BUS_RVALID,
  input  wire             CFG_DONE_EVT,
  output wire             IRQ_REQ,
  output wire             PROGRAM_PIN_N,
  input  wire [2:0]       CONFIG_OFFSET_PINS,
  output wire [2:0]       CONFIG_OFFSET,
  input  wire             PARSE_DONE,
  input  wire             MASTER_RECORD_FOUND,
  input  wire             PARTITION_RECORD_FOUND,
  input  wire             MASTER_RECORD_FAT12_MARK,
  input  wire             PARTITION_RECORD_FAT12_MARK,
  input  wire             MASTER_RECORD_FAT16_MARK,
  input  wire             PARTITION_RECORD_FAT16_MARK,
  input  wire [CNT_W-1:0] CLUSTER_COUNT
);

  reg         offset_override_select_ff;
  reg         done_interrupt_enable_ff;
  reg         interrupt_line_clear_ff;
  reg         program_pin_drive_ff;
  reg  [2:0]  cfg_offset_ff;
  reg         irq_ff;
  reg         prog_n_ff;
  wire [2:0]  pins_sync;
  reg  [2:0]  offset_out_ff;
  reg  [7:0]  fat_stat_ff;
  reg  [15:0] rdata_ff;
  reg         rvalid_ff;

  reg         nxt_offset_override_select;
  reg         nxt_done_interrupt_enable;
  reg         nxt_interrupt_line_clear;
  reg         nxt_program_pin_drive;
  reg  [2:0]  nxt_cfg_offset;
  reg         nxt_irq;
  reg  [15:0] nxt_rdata;
  reg  [7:0]  nxt_fat_stat;

  wire wr_lo = BUS_WR && (BUS_ADDR == `CFGRG_ADDR_CTRL_LO);
  wire wr_hi = BUS_WR && (BUS_ADDR == `CFGRG_ADDR_CTRL_HI);
  wire [31:0] ctrl_rd;
  wire computed_fat12_type;
  wire computed_fat16_type;

  // Control register writes; only bits 2 and 10..15 are stored, 16..31 are dropped
  always @*
  begin
    nxt_offset_override_select = offset_override_select_ff;
    nxt_done_interrupt_enable  = done_interrupt_enable_ff;
    nxt_interrupt_line_clear   = interrupt_line_clear_ff;
    nxt_program_pin_drive      = program_pin_drive_ff;
    nxt_cfg_offset             = cfg_offset_ff;
    if ((wr_lo && BUS_BE[0]) || (wr_hi && BUS_BE[0]))
    begin
      if (wr_lo)
        nxt_offset_override_select = BUS_WDATA[`CFGRG_CTRL_OVR_BIT];
    end
    if (wr_lo && BUS_BE[1])
    begin
      nxt_done_interrupt_enable = BUS_WDATA[`CFGRG_CTRL_DIE_BIT]; // RULE_01
      nxt_interrupt_line_clear  = BUS_WDATA[`CFGRG_CTRL_CLR_BIT]; // RULE_02
      nxt_program_pin_drive     = BUS_WDATA[`CFGRG_CTRL_PROG_BIT]; // RULE_04
      nxt_cfg_offset            = BUS_WDATA[`CFGRG_CTRL_OFS_MSB:`CFGRG_CTRL_OFS_LSB]; // RULE_05
    end
  end

  // Interrupt line: clear bit forces it low and blocks new requests until rewritten to zero
  always @*
  begin
    nxt_irq = irq_ff;
    if (CFG_DONE_EVT && nxt_done_interrupt_enable)
      nxt_irq = 1'b1; // RULE_01
    if (nxt_interrupt_line_clear)
      nxt_irq = 1'b0; // RULE_02 RULE_03
  end

  assign computed_fat12_type = (CLUSTER_COUNT < `CFGRG_FAT12_LIMIT); // RULE_13
  assign computed_fat16_type = (CLUSTER_COUNT > `CFGRG_FAT12_LIMIT) &&
                               (CLUSTER_COUNT < `CFGRG_FAT16_LIMIT); // RULE_14

  // Status snapshot of the first valid partition, taken when parsing completes
  always @*
  begin
    nxt_fat_stat = fat_stat_ff;
    if (PARSE_DONE) // RULE_16
      nxt_fat_stat = {computed_fat16_type, computed_fat12_type,
                      PARTITION_RECORD_FAT16_MARK, MASTER_RECORD_FAT16_MARK,
                      PARTITION_RECORD_FAT12_MARK, MASTER_RECORD_FAT12_MARK,
                      PARTITION_RECORD_FOUND, MASTER_RECORD_FOUND}; // RULE_08 RULE_09 RULE_10 RULE_11 RULE_12
  end

  assign ctrl_rd = {16'h0000, cfg_offset_ff, program_pin_drive_ff, interrupt_line_clear_ff,
                    done_interrupt_enable_ff, 7'h00, offset_override_select_ff, 2'h0};

  // Read mux; unmapped addresses return zero, reads change no state
  always @*
  begin
    case (BUS_ADDR)
      `CFGRG_ADDR_CTRL_LO:
        nxt_rdata = ctrl_rd[15:0];
      `CFGRG_ADDR_CTRL_HI:
        nxt_rdata = ctrl_rd[31:16]; // RULE_07
      `CFGRG_ADDR_FATSTAT:
        nxt_rdata = {8'h00, fat_stat_ff}; // RULE_15
      default:
        nxt_rdata = 16'h0000;
    endcase
  end

  // Two-stage synchroniser per offset pin; only the second stage is read
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_pin_sync
      reg meta_ff;
      reg sync_ff;
      always @(posedge SYS_CLK or posedge RST)
      begin
        if (RST)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= CONFIG_OFFSET_PINS[g];
          sync_ff <= meta_ff;
        end
      end
      assign pins_sync[g] = sync_ff;
    end
  endgenerate

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      offset_override_select_ff <= 1'b0;
    end
    else
    begin
      offset_override_select_ff <= nxt_offset_override_select; // RULE_06
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      done_interrupt_enable_ff <= 1'b0;
    end
    else
    begin
      done_interrupt_enable_ff <= nxt_done_interrupt_enable; // RULE_01
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      interrupt_line_clear_ff <= 1'b0;
    end
    else
    begin
      interrupt_line_clear_ff <= nxt_interrupt_line_clear; // RULE_03
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      program_pin_drive_ff <= 1'b0;
    end
    else
    begin
      program_pin_drive_ff <= nxt_program_pin_drive; // RULE_04
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg_offset_ff <= 3'h0;
    end
    else
    begin
      cfg_offset_ff <= nxt_cfg_offset; // RULE_05
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq; // RULE_02
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      prog_n_ff <= 1'b1;
    end
    else
    begin
      prog_n_ff <= ~nxt_program_pin_drive; // RULE_04
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      offset_out_ff <= 3'h0;
    end
    else
    begin
      offset_out_ff <= nxt_offset_override_select ? nxt_cfg_offset
                                                  : pins_sync; // RULE_06
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      fat_stat_ff <= `CFGRG_FAT_RST;
    end
    else
    begin
      fat_stat_ff <= nxt_fat_stat; // RULE_16
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= BUS_RD ? nxt_rdata : 16'h0000;
    end
  end

  always @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= BUS_RD;
    end
  end

  assign BUS_RDATA     = rdata_ff;
  assign BUS_RVALID    = rvalid_ff;
  assign IRQ_REQ       = irq_ff;
  assign PROGRAM_PIN_N = prog_n_ff;
  assign CONFIG_OFFSET = offset_out_ff;

endmodule // cfgrg_regs

// >>> tb/cfg_control_fat_status_regs_bench.sv
// Bench for cfgrg_regs: host model on the bus, bench drives events and parser results.
// Assumes read data comes one edge after the strobe.
`timescale 1ns/1ps
module cfg_control_fat_status_regs_bench;
  reg         SYS_CLK = 0;
  reg         RST = 1;
  reg         CFG_DONE_EVT = 0;
  reg         PARSE_DONE = 0;
  reg  [5:0]  flg = 0;
  reg  [2:0]  pins = 0;
  reg  [31:0] cnt = 0;
  reg  [31:0] seed = 32'h0000_208b;
  reg  [15:0] ex;
  reg  [15:0] expq[$];
  wire [6:0]  BUS_ADDR;
  wire [1:0]  BUS_BE;
  wire [15:0] BUS_WDATA, BUS_RDATA;
  wire [2:0]  CONFIG_OFFSET;
  wire        BUS_WR, BUS_RD, BUS_RVALID, IRQ_REQ, PROGRAM_PIN_N;
  integer     i, failures = 0, samples_checked = 0;
  always #2.5 SYS_CLK = ~SYS_CLK;
  cfgrg_host host (.SYS_CLK(SYS_CLK), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
    .BUS_BE(BUS_BE), .BUS_WDATA(BUS_WDATA));
  cfgrg_regs dut (.SYS_CLK(SYS_CLK), .RST(RST), .BUS_ADDR(BUS_ADDR), .BUS_WR(BUS_WR),
    .BUS_RD(BUS_RD), .BUS_BE(BUS_BE), .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA),
    .BUS_RVALID(BUS_RVALID), .CFG_DONE_EVT(CFG_DONE_EVT), .IRQ_REQ(IRQ_REQ),
    .PROGRAM_PIN_N(PROGRAM_PIN_N), .CONFIG_OFFSET_PINS(pins), .CONFIG_OFFSET(CONFIG_OFFSET),
    .PARSE_DONE(PARSE_DONE), .MASTER_RECORD_FOUND(flg[0]), .PARTITION_RECORD_FOUND(flg[1]),
    .MASTER_RECORD_FAT12_MARK(flg[2]), .PARTITION_RECORD_FAT12_MARK(flg[3]),
    .MASTER_RECORD_FAT16_MARK(flg[4]), .PARTITION_RECORD_FAT16_MARK(flg[5]),
    .CLUSTER_COUNT(cnt));
  task chk(input [15:0] seen, input [15:0] exp, input string nm);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rd(input [6:0] a, input [15:0] e);
    begin
      expq.push_back(e);
      host.xfer(1'b1, a, 16'h0000);
    end
  endtask
  task wc(input [15:0] d);
    host.xfer(1'b0, 7'h18, d);
  endtask
  task ev;
    begin
      CFG_DONE_EVT = 1;
      @(posedge SYS_CLK);
      #1 CFG_DONE_EVT = 0;
    end
  endtask
  task conclude;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Read data is matched against the oldest expectation
  always @(negedge SYS_CLK)
    if (BUS_RVALID === 1'b1)
      chk(BUS_RDATA, expq.pop_front(), "rdata");
  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    #1 RST = 0;
    chk(IRQ_REQ, 0, "irq");
    chk(PROGRAM_PIN_N, 1, "prog");
    rd(7'h1C, 16'h0000);
    rd(7'h18, 16'h0000);
    for (i = 0; i < 8; i = i + 1)
    begin
      cnt = (i < 3) ? 32'h0000_0ff4 + i : (i < 5) ? 32'h0000_fff1 + i : $random(seed) & 32'h0001_ffff;
      flg = $random(seed);
      PARSE_DONE = 1;
      @(posedge SYS_CLK);
      #1 PARSE_DONE = 0;
      ex = {8'h00, cnt > 32'h0000_0ff5 && cnt < 32'h0000_fff5, cnt < 32'h0000_0ff5, flg};
      rd(7'h1C, ex);
    end
    host.xfer(1'b0, 7'h1C, 16'hffff);
    rd(7'h1C, ex);
    rd(7'h30, 16'h0000);
    host.xfer(1'b0, 7'h1A, 16'hffff);
    rd(7'h1A, 16'h0000);
    pins = $random(seed);
    repeat (4) @(posedge SYS_CLK);
    #1 chk(CONFIG_OFFSET, pins, "pins");
    ex = {pins + 3'h1, 13'h1004};
    wc(ex);
    chk(CONFIG_OFFSET, ex[15:13], "ofs");
    chk(PROGRAM_PIN_N, 0, "prog");
    rd(7'h18, ex);
    wc(16'he000);
    chk(CONFIG_OFFSET, pins, "pins");
    chk(PROGRAM_PIN_N, 1, "prog");
    wc(16'h0400);
    ev;
    chk(IRQ_REQ, 1, "irq");
    wc(16'h0c00);
    chk(IRQ_REQ, 0, "irq");
    ev;
    chk(IRQ_REQ, 0, "irq");
    wc(16'h0400);
    ev;
    chk(IRQ_REQ, 1, "irq");
    wc(16'h0800);
    wc(16'h0000);
    ev;
    chk(IRQ_REQ, 0, "irq");
    RST = 1;
    @(posedge SYS_CLK);
    #1 RST = 0;
    chk(PROGRAM_PIN_N, 1, "prog");
    rd(7'h1C, 16'h0000);
    for (i = 0; i < 10 && expq.size() > 0; i = i + 1)
      @(posedge SYS_CLK);
    if (expq.size() > 0)
      failures = failures + 1;
    conclude;
  end
endmodule // cfg_control_fat_status_regs_bench

// >>> tb/cfgrg_host.sv
// Host model: one-cycle word reads and writes on the register bus.
// Assumes strobes are taken on the rising clock edge.
`timescale 1ns/1ps
module cfgrg_host (
  input  wire        SYS_CLK,
  output reg  [6:0]  BUS_ADDR,
  output reg         BUS_WR,
  output reg         BUS_RD,
  output reg  [1:0]  BUS_BE,
  output reg  [15:0] BUS_WDATA
);
  initial {BUS_ADDR, BUS_WR, BUS_RD, BUS_BE, BUS_WDATA} = 0;
  task xfer(input rd, input [6:0] a, input [15:0] d);
    begin
      @(posedge SYS_CLK);
      #1 BUS_ADDR = a;
      BUS_BE = 2'b11;
      BUS_WDATA = (a == 7'h1A) ? (d & 16'hfff8) : d;
      {BUS_RD, BUS_WR} = {rd, !rd};
      @(posedge SYS_CLK);
      #1 {BUS_RD, BUS_WR} = 2'b00;
      BUS_ADDR = ~a;
      BUS_WDATA = ~BUS_WDATA;
    end
  endtask
endmodule // cfgrg_host

// >>> tb/cfgrg_regs_sva.sv
// Checker for the control and file-system status register block.
// Sees only the ports of cfgrg_regs; bound below.
`timescale 1ns/1ps
module cfgrg_chk (
  input wire        SYS_CLK,
  input wire        RST,
  input wire [6:0]  BUS_ADDR,
  input wire        BUS_WR,
  input wire        BUS_RD,
  input wire [1:0]  BUS_BE,
  input wire [15:0] BUS_WDATA,
  input wire [15:0] BUS_RDATA,
  input wire        BUS_RVALID,
  input wire        CFG_DONE_EVT,
  input wire        IRQ_REQ,
  input wire        PROGRAM_PIN_N,
  input wire [2:0]  CONFIG_OFFSET
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  wire wc = BUS_WR && BUS_ADDR == 7'h18 && BUS_BE[1];
  wire rs = BUS_RD && BUS_ADDR == 7'h1C;
  property p_rise; $rose(IRQ_REQ) |-> $past(CFG_DONE_EVT); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without event");
  property p_hold; IRQ_REQ && !(wc && BUS_WDATA[11]) |=> IRQ_REQ; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped alone");
  property p_clr; wc && BUS_WDATA[11] |=> !IRQ_REQ; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_arm; wc && BUS_WDATA[11] ##1 !wc |=> !IRQ_REQ; endproperty
  a_arm: assert property (p_arm) else $error("irq raised while clear held");
  property p_prog; wc |=> PROGRAM_PIN_N == !$past(BUS_WDATA[12]); endproperty
  a_prog: assert property (p_prog) else $error("program pin wrong");
  property p_ofs; wc && BUS_BE[0] && BUS_WDATA[2] |=> CONFIG_OFFSET == $past(BUS_WDATA[15:13]);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset not from register");
  property p_rv; BUS_RD |=> BUS_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_rz; $past(rs) |-> BUS_RDATA[15:8] == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("status high byte not zero");
endmodule // cfgrg_chk
bind cfgrg_regs cfgrg_chk u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .BUS_ADDR(BUS_ADDR),
  .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_BE(BUS_BE), .BUS_WDATA(BUS_WDATA),
  .BUS_RDATA(BUS_RDATA), .BUS_RVALID(BUS_RVALID), .CFG_DONE_EVT(CFG_DONE_EVT),
  .IRQ_REQ(IRQ_REQ), .PROGRAM_PIN_N(PROGRAM_PIN_N), .CONFIG_OFFSET(CONFIG_OFFSET));
